// ---- shared/fifo_ptr_pkg.sv ----
package fifo_ptr_pkg;

  // Widths
  localparam int PTR_W      = 14;
  localparam int HIGH_W     = 6;
  localparam int BYTE_W     = 8;
  localparam int XADDR_W    = 16;

  // Register byte addresses on the microcontroller data space
  localparam logic [XADDR_W-1:0] REG_PTR_LOW  = 16'hf0eb;
  localparam logic [XADDR_W-1:0] REG_PTR_HIGH = 16'hf0ec;

  // Field positions
  localparam int LOW_MSB    = 7;
  localparam int HIGH_LSB   = 8;
  localparam int HIGH_MSB   = 13;
  localparam int EMPTY_BIT  = 7;

  // Reset and fixed values
  localparam logic [PTR_W-1:0]  PTR_RST  = 14'h0000;
  localparam logic [PTR_W-1:0]  PTR_STEP = 14'h0001;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic              RSV_VAL  = 1'b0;
  localparam logic              FLAG_RST = 1'b0;

  // Pointer operation chosen in a cycle, highest priority first
  typedef enum logic [2:0] {
    OP_CLEAR,
    OP_ABORT,
    OP_CONFIRM,
    OP_WRITE,
    OP_IDLE
  } ptr_op_e;

endpackage : fifo_ptr_pkg

// ---- shared/ptr_if.sv ----
`timescale 1ns/1ps
interface ptr_if;
  import fifo_ptr_pkg::*;

  logic             write;
  logic             confirm;
  logic             abort;
  logic             clear;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] cur_q;
  logic [PTR_W-1:0] bk_q;
  logic [PTR_W-1:0] cur_d;
  logic [PTR_W-1:0] bk_d;

  modport core (
    input  write, confirm, abort, clear, rd_ptr,
    output cur_q, bk_q, cur_d, bk_d
  );

  modport ctrl (
    output write, confirm, abort, clear, rd_ptr,
    input  cur_q, bk_q, cur_d, bk_d
  );

endinterface : ptr_if

// ---- hw/write_ptr_core.sv ----
`timescale 1ns/1ps
module write_ptr_core
  import fifo_ptr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pointer control and state
  ptr_if.core      pif
);

  logic [PTR_W-1:0] cur_q;
  logic [PTR_W-1:0] cur_d;
  logic [PTR_W-1:0] bk_q;
  logic [PTR_W-1:0] bk_d;
  ptr_op_e          op;

  always_comb begin
    if (pif.clear) begin
      op = OP_CLEAR;
    end else if (pif.abort) begin
      op = OP_ABORT;
    end else if (pif.confirm) begin
      op = OP_CONFIRM;
    end else if (pif.write) begin
      op = OP_WRITE;
    end else begin
      op = OP_IDLE;
    end
  end

  always_comb begin
    cur_d = cur_q;
    bk_d  = bk_q;
    unique case (op)
      OP_CLEAR: begin
        // Both pointers meet the reader, so nothing is left to read
        cur_d = pif.rd_ptr;
        bk_d  = pif.rd_ptr;
      end
      OP_ABORT: begin
        cur_d = bk_q;
      end
      OP_CONFIRM: begin
        // A write in the confirm cycle is kept but left unconfirmed
        bk_d = cur_q;
        if (pif.write) begin
          cur_d = cur_q + PTR_STEP;
        end
      end
      OP_WRITE: begin
        cur_d = cur_q + PTR_STEP;
      end
      OP_IDLE: begin
        cur_d = cur_q;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= PTR_RST;
      bk_q  <= PTR_RST;
    end else begin
      cur_q <= cur_d;
      bk_q  <= bk_d;
    end
  end

  assign pif.cur_q = cur_q;
  assign pif.bk_q  = bk_q;
  assign pif.cur_d = cur_d;
  assign pif.bk_d  = bk_d;

  property p_abort_restore;
    @(posedge clk) disable iff (!rst_n)
    (pif.abort && !pif.clear) |=> (cur_q == $past(bk_q)) && $stable(bk_q);
  endproperty
  a_abort_restore: assert property (p_abort_restore) else $error("abort did not restore pointer");

  property p_confirm_copy;
    @(posedge clk) disable iff (!rst_n)
    (pif.confirm && !pif.abort && !pif.clear) |=> bk_q == $past(cur_q);
  endproperty
  a_confirm_copy: assert property (p_confirm_copy) else $error("confirm did not copy pointer");

  property p_advance;
    @(posedge clk) disable iff (!rst_n)
    (pif.write && !pif.abort && !pif.clear) |=> cur_q == $past(cur_q) + PTR_STEP;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance by one");

  property p_clear_meet;
    @(posedge clk) disable iff (!rst_n)
    pif.clear |=> (cur_q == $past(pif.rd_ptr)) && (bk_q == $past(pif.rd_ptr));
  endproperty
  a_clear_meet: assert property (p_clear_meet) else $error("clear did not empty pointers");

endmodule : write_ptr_core

// ---- hw/sector_fifo_write_pointer.sv ----
`timescale 1ns/1ps
module sector_fifo_write_pointer
  import fifo_ptr_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // USB buffer manager write side
  input  wire logic               wr_valid,
  input  wire logic [BYTE_W-1:0]  wr_data,
  input  wire logic               data_confirm,
  input  wire logic               crc_error,
  // Microcontroller FIFO-clear control
  input  wire logic               fifo_clear_control,
  // Read side of the FIFO
  input  wire logic [PTR_W-1:0]   rd_ptr,
  output logic      [PTR_W-1:0]   readable_limit,
  // FIFO memory write port
  output logic                    fifo_wr_en,
  output logic      [PTR_W-1:0]   fifo_wr_addr,
  output logic      [BYTE_W-1:0]  fifo_wr_data,
  // Microcontroller register read
  input  wire logic [XADDR_W-1:0] xdata_addr,
  input  wire logic               xdata_rd,
  output logic      [BYTE_W-1:0]  xdata_rdata
);

  ptr_if pif ();

  logic                wr_accept;
  logic                fifo_wr_en_q;
  logic                fifo_wr_en_d;
  logic [PTR_W-1:0]    fifo_wr_addr_q;
  logic [PTR_W-1:0]    fifo_wr_addr_d;
  logic [BYTE_W-1:0]   fifo_wr_data_q;
  logic [BYTE_W-1:0]   fifo_wr_data_d;
  logic [PTR_W-1:0]    limit_q;
  logic [PTR_W-1:0]    limit_d;
  logic                fifo_empty_flag_q;
  logic                fifo_empty_flag_d;
  logic [BYTE_W-1:0]   rdata_q;
  logic [BYTE_W-1:0]   rdata_d;
  logic [BYTE_W-1:0]   fifo_write_pointer_low;
  logic [BYTE_W-1:0]   fifo_write_pointer_high_and_empty;

  // A write that meets a CRC error or a clear is dropped outright
  assign wr_accept = wr_valid && !crc_error && !fifo_clear_control;

  assign pif.write   = wr_accept;
  assign pif.confirm = data_confirm;
  assign pif.abort   = crc_error;
  assign pif.clear   = fifo_clear_control;
  assign pif.rd_ptr  = rd_ptr;

  write_ptr_core u_core (
    .clk   (clk),
    .rst_n (rst_n),
    .pif   (pif.core)
  );

  // Memory write strobe, address and data
  always_comb begin
    fifo_wr_en_d   = wr_accept;
    fifo_wr_addr_d = fifo_wr_addr_q;
    fifo_wr_data_d = fifo_wr_data_q;
    if (wr_accept) begin
      fifo_wr_addr_d = pif.cur_q;
      fifo_wr_data_d = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_wr_en_q   <= FLAG_RST;
      fifo_wr_addr_q <= PTR_RST;
      fifo_wr_data_q <= BYTE_RST;
    end else begin
      fifo_wr_en_q   <= fifo_wr_en_d;
      fifo_wr_addr_q <= fifo_wr_addr_d;
      fifo_wr_data_q <= fifo_wr_data_d;
    end
  end

  // Read-side limit and empty flag
  always_comb begin
    // Only confirmed data is exposed to the reader
    limit_d = pif.bk_d;
    // Taken from next values so the flag tracks the pointers without lag
    fifo_empty_flag_d = (pif.cur_d == pif.bk_d) && (pif.bk_d == rd_ptr);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_q           <= PTR_RST;
      fifo_empty_flag_q <= FLAG_RST;
    end else begin
      limit_q           <= limit_d;
      fifo_empty_flag_q <= fifo_empty_flag_d;
    end
  end

  // Register read port
  assign fifo_write_pointer_low = pif.cur_q[LOW_MSB:0];
  assign fifo_write_pointer_high_and_empty = {fifo_empty_flag_q, RSV_VAL, pif.cur_q[HIGH_MSB:HIGH_LSB]};

  always_comb begin
    rdata_d = rdata_q;
    if (xdata_rd) begin
      unique case (xdata_addr)
        REG_PTR_LOW:  rdata_d = fifo_write_pointer_low;
        REG_PTR_HIGH: rdata_d = fifo_write_pointer_high_and_empty;
        default:      rdata_d = BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= BYTE_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign fifo_wr_en     = fifo_wr_en_q;
  assign fifo_wr_addr   = fifo_wr_addr_q;
  assign fifo_wr_data   = fifo_wr_data_q;
  assign readable_limit = limit_q;
  assign xdata_rdata    = rdata_q;

  property p_read_low;
    @(posedge clk) disable iff (!rst_n)
    (xdata_rd && xdata_addr == REG_PTR_LOW) |=> xdata_rdata == $past(pif.cur_q[LOW_MSB:0]);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low pointer byte read wrong");

  property p_read_high;
    @(posedge clk) disable iff (!rst_n)
    (xdata_rd && xdata_addr == REG_PTR_HIGH)
      |=> (xdata_rdata[HIGH_W-1:0] == $past(pif.cur_q[HIGH_MSB:HIGH_LSB]))
          && (xdata_rdata[EMPTY_BIT-1] == RSV_VAL)
          && (xdata_rdata[EMPTY_BIT] == $past(fifo_empty_flag_q));
  endproperty
  a_read_high: assert property (p_read_high) else $error("high pointer byte read wrong");

  property p_write_at_pointer;
    @(posedge clk) disable iff (!rst_n)
    wr_accept |=> fifo_wr_en && (fifo_wr_addr == $past(pif.cur_q)) && (fifo_wr_data == $past(wr_data));
  endproperty
  a_write_at_pointer: assert property (p_write_at_pointer) else $error("write not at current pointer");

  property p_limit_hidden;
    @(posedge clk) disable iff (!rst_n)
    (!data_confirm && !fifo_clear_control) ##1 (!data_confirm && !fifo_clear_control)
      |=> $stable(readable_limit);
  endproperty
  a_limit_hidden: assert property (p_limit_hidden) else $error("unconfirmed data became visible");

  property p_not_empty_after_write;
    @(posedge clk) disable iff (!rst_n)
    (wr_accept && !data_confirm) |=> !fifo_empty_flag_q;
  endproperty
  a_not_empty_after_write: assert property (p_not_empty_after_write) else $error("empty flag set after write");

  property p_empty_after_clear;
    @(posedge clk) disable iff (!rst_n)
    (fifo_clear_control && $stable(rd_ptr)) |=> fifo_empty_flag_q;
  endproperty
  a_empty_after_clear: assert property (p_empty_after_clear) else $error("clear did not empty FIFO");

  property p_limit_follows_confirm;
    @(posedge clk) disable iff (!rst_n)
    (data_confirm && !crc_error && !fifo_clear_control) |=> readable_limit == $past(pif.cur_q);
  endproperty
  a_limit_follows_confirm: assert property (p_limit_follows_confirm) else $error("limit not the confirmed pointer");

  property p_abort_drops_write;
    @(posedge clk) disable iff (!rst_n)
    crc_error |=> !fifo_wr_en;
  endproperty
  a_abort_drops_write: assert property (p_abort_drops_write) else $error("write kept on CRC error");

endmodule : sector_fifo_write_pointer

// ---- verif/usb_buffer_manager_model.sv ----
`timescale 1ns/1ps
module usb_buffer_manager_model
  import fifo_ptr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Bench command
  input  wire logic              start,
  input  wire logic [4:0]        count,
  input  wire logic              crc_mode,
  output logic                   busy,
  // Write side toward the block
  output logic                   wr_valid,
  output logic      [BYTE_W-1:0] wr_data,
  output logic                   data_confirm,
  output logic                   crc_error
);
  logic [4:0] left_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy         <= 1'b0;
      left_q       <= 5'h00;
      wr_valid     <= 1'b0;
      wr_data      <= 8'h00;
      data_confirm <= 1'b0;
      crc_error    <= 1'b0;
    end else begin
      wr_valid     <= 1'b0;
      data_confirm <= 1'b0;
      crc_error    <= 1'b0;
      // Idle data toggles so a stale byte never looks valid
      wr_data      <= ~wr_data;
      if (start && !busy) begin
        busy   <= 1'b1;
        left_q <= count;
      end else if (busy) begin
        if (left_q != 5'h00) begin
          // Random gaps give both prompt and slow streams
          if ($urandom_range(3) != 0) begin
            wr_valid <= 1'b1;
            wr_data  <= 8'($urandom);
            left_q   <= left_q - 5'h01;
          end
        end else begin
          busy <= 1'b0;
          if (crc_mode) begin
            // Abort lands together with one more item, which must be dropped
            crc_error <= 1'b1;
            wr_valid  <= 1'b1;
            wr_data   <= 8'($urandom);
          end else begin
            data_confirm <= 1'b1;
            // Companion write stays unconfirmed, so the processor must clear
            if ($urandom_range(3) == 0) begin
              wr_valid <= 1'b1;
              wr_data  <= 8'($urandom);
            end
          end
        end
      end
    end
  end
endmodule : usb_buffer_manager_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
  import fifo_ptr_pkg::*;
;
  logic clk, rst_n, start, crc_mode, busy, wr_valid, data_confirm, crc_error, clr;
  logic fifo_wr_en, xdata_rd;
  logic [4:0]         count;
  logic [BYTE_W-1:0]  wr_data, fifo_wr_data, xdata_rdata, e_data, e_rd;
  logic [PTR_W-1:0]   rd_ptr, readable_limit, fifo_wr_addr, m_cur, m_bk, e_addr, n_cur, n_bk;
  logic [XADDR_W-1:0] xdata_addr;
  logic               m_empty, e_en;
  int                 bad_count, checks;

  usb_buffer_manager_model u_usb_buffer_manager_model (.clk(clk), .rst_n(rst_n), .start(start),
    .count(count), .crc_mode(crc_mode), .busy(busy), .wr_valid(wr_valid), .wr_data(wr_data),
    .data_confirm(data_confirm), .crc_error(crc_error));
  sector_fifo_write_pointer u_sector_fifo_write_pointer (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_data(wr_data), .data_confirm(data_confirm), .crc_error(crc_error), .fifo_clear_control(clr),
    .rd_ptr(rd_ptr), .readable_limit(readable_limit), .fifo_wr_en(fifo_wr_en), .fifo_wr_addr(fifo_wr_addr),
    .fifo_wr_data(fifo_wr_data), .xdata_addr(xdata_addr), .xdata_rd(xdata_rd), .xdata_rdata(xdata_rdata));

  function automatic logic [BYTE_W-1:0] reg_val(logic [XADDR_W-1:0] a, logic [PTR_W-1:0] c, logic e);
    if (a == REG_PTR_LOW) return c[7:0];
    if (a == REG_PTR_HIGH) return {e, 1'b0, c[13:8]};
    return 8'h00;
  endfunction : reg_val

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reference pointers; outputs are compared against the previous edge's prediction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {m_cur, m_bk, m_empty, e_en, e_addr, e_data, e_rd} = '0;
    end else begin
      `CHK(fifo_wr_en, e_en)
      `CHK(fifo_wr_addr, e_addr)
      `CHK(fifo_wr_data, e_data)
      `CHK(readable_limit, m_bk)
      `CHK(xdata_rdata, e_rd)
      if (xdata_rd) e_rd = reg_val(xdata_addr, m_cur, m_empty);
      e_en = wr_valid && !crc_error && !clr;
      if (e_en) begin
        e_addr = m_cur;
        e_data = wr_data;
      end
      n_cur = e_en ? m_cur + PTR_STEP : m_cur;
      n_bk = (data_confirm && !crc_error) ? m_cur : m_bk;
      if (crc_error) n_cur = m_bk;
      if (clr) {n_cur, n_bk} = {rd_ptr, rd_ptr};
      m_empty = (n_cur == n_bk) && (n_bk == rd_ptr);
      {m_cur, m_bk} = {n_cur, n_bk};
    end
  end

  task automatic clear_to(logic [PTR_W-1:0] p);
    @(posedge clk);
    clr    <= 1'b1;
    rd_ptr <= p;
    @(posedge clk);
    clr    <= 1'b0;
  endtask : clear_to

  task automatic check_empty();
    @(posedge clk);
    xdata_rd   <= 1'b1;
    xdata_addr <= REG_PTR_HIGH;
    @(posedge clk);
    xdata_rd   <= 1'b0;
    @(posedge clk);
    // Processor side: no data command while the flag is clear
    if (xdata_rdata[EMPTY_BIT] !== 1'b1) clear_to(14'(rd_ptr + 14'h0011));
  endtask : check_empty

  task automatic run(int n, logic crc);
    int k;
    @(posedge clk);
    start    <= 1'b1;
    count    <= 5'(n);
    crc_mode <= crc;
    @(posedge clk);
    start    <= 1'b0;
    // Busy is only seen one edge after the model takes the start
    @(posedge clk);
    for (k = 0; k < 200 && busy === 1'b1; k++) begin
      @(posedge clk);
      // Background reads, unmapped address included
      xdata_rd <= 1'($urandom_range(1));
      case ($urandom_range(2))
        0:       xdata_addr <= REG_PTR_LOW;
        1:       xdata_addr <= REG_PTR_HIGH;
        default: xdata_addr <= 16'hf0ed;
      endcase
    end
    if (k == 200) bad_count++;
    @(posedge clk);
    xdata_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : run

  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial begin
    {rst_n, start, crc_mode, clr, xdata_rd} = '0;
    {count, rd_ptr, xdata_addr} = '0;
    bad_count = 0;
    checks = 0;
    void'($urandom(23488));
    repeat (10) @(posedge clk);
    xdata_rd <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(xdata_rdata, BYTE_RST)
    `CHK(readable_limit, PTR_RST)
    xdata_rd <= 1'b0;
    rst_n    <= 1'b1;
    repeat (2) @(posedge clk);
    // Pointer placed near the top so the stream wraps to zero
    clear_to(14'h3ffd);
    run(8, 1'b0);
    for (int i = 0; i < 60; i++) begin
      check_empty();
      run($urandom_range(1, 20), 1'($urandom_range(3) == 0));
      // Reader drains to the limit only some of the time
      @(posedge clk);
      if ($urandom_range(1)) rd_ptr <= m_bk;
    end
    check_empty();
    print_verdict();
  end
endmodule : testbench
